/* fmtc_defs.svh */
// Constants of the FM tuning control block: byte indices, bit fields,
// reset values and timing figures.
// Assumes one inclusion per file; the guard below tolerates more.
`ifndef FMTC_DEFS_SVH
`define FMTC_DEFS_SVH

// ****************************************
// Serial byte map
// ****************************************
`define FMTC_IDX_W 4
`define FMTC_REG_STATUS 4'h0
`define FMTC_REG_IFCOUNT 4'h1
`define FMTC_REG_TUNE_HIGH 4'h2
`define FMTC_REG_TUNE_LOW 4'h3
`define FMTC_REG_CTRL_ONE 4'h4
`define FMTC_REG_CTRL_TWO 4'h5
`define FMTC_REG_TEST_BITS 4'h6
`define FMTC_REG_TEST_SEL 4'h7

// ****************************************
// Bit fields
// ****************************************
`define FMTC_B_SEARCH 7
`define FMTC_B_SCAN_UP 6
`define FMTC_B_BAND 0
`define FMTC_B_LOCAL 1
`define FMTC_B_PERIOD 2
`define FMTC_B_AGC_OFF 3
`define FMTC_B_REF_EXT 4
`define FMTC_WORD_W 14
`define FMTC_IFC_W 7
`define FMTC_BYTE_RESET 8'h00

// ****************************************
// Timing
// ****************************************
`define FMTC_CLK_PS 5000
`define FMTC_T_LOCK_MIN_US 2000
`define FMTC_T_LOCK_MAX_US 10000
`define FMTC_T_SHORT_US 2000
`define FMTC_T_LONG_US 15600
// 64-bit product: microseconds times a million overflows a plain int
`define FMTC_CYC_UP(us) (((us) * 64'd1000000 + `FMTC_CLK_PS - 1) / `FMTC_CLK_PS)
`define FMTC_CYC_DN(us) (((us) * 64'd1000000) / `FMTC_CLK_PS)
`define FMTC_TMR_W 22
`define FMTC_DEV_ADDR 7'h11

`endif

/* fmtc_pkg.sv */
// Types shared by the FM tuning control block.
// Assumes fmtc_defs.svh holds every number.
package fmtc_pkg;
	// Tuning sequence, Gray along idle-lock-count-update
	typedef enum logic [1:0] {
		TUNE_IDLE = 2'b00,
		TUNE_LOCK = 2'b01,
		TUNE_COUNT = 2'b11,
		TUNE_RDS = 2'b10
	} fmtc_tune_t;

	// Serial slave phases
	typedef enum logic [2:0] {
		SER_IDLE = 3'b000,
		SER_RX = 3'b001,
		SER_ACK = 3'b011,
		SER_TX = 3'b010,
		SER_RACK = 3'b110
	} fmtc_ser_t;
endpackage : fmtc_pkg

/* fmtc_bus_if.sv */
// Byte access path between the serial slave and the control registers.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`include "fmtc_defs.svh"

interface fmtc_bus_if;
	logic wr_stb;
	logic [`FMTC_IDX_W-1:0] idx;
	logic [7:0] wr_data;
	logic [7:0] rd_data;

	modport slave (output wr_stb, output idx, output wr_data,
		input rd_data);
	modport regs (input wr_stb, input idx, input wr_data,
		output rd_data);
endinterface : fmtc_bus_if

/* fmtc_i2c.sv */
// Serial byte slave: address match, index byte, auto-increment access.
// Assumes scl and sda arrive already through two flip-flops.
`timescale 1ns/1ps
`include "fmtc_defs.svh"

module fmtc_i2c
	import fmtc_pkg::*;
(
	input wire logic clk, // System clock
	input wire logic rst_b, // Async reset, low
	input wire logic gate, // Bus enabled
	input wire logic scl_s, // Synchronised clock line
	input wire logic sda_s, // Synchronised data line
	output logic sda_oe, // Pull data line low
	fmtc_bus_if.slave bus // Register access
);
	fmtc_ser_t st, next_st;
	logic [3:0] bitc, next_bitc;
	logic [7:0] sh, next_sh;
	logic [`FMTC_IDX_W-1:0] idx, next_idx;
	logic scl_p, sda_p, rw, next_rw, aph, next_aph, ixp, next_ixp;
	logic next_oe, next_wr;
	logic rise, fall, start, stop;

	// ****************************************
	// Line events
	// ****************************************
	assign rise = scl_s & ~scl_p;
	assign fall = ~scl_s & scl_p;
	assign start = scl_s & scl_p & sda_p & ~sda_s;
	assign stop = scl_s & scl_p & ~sda_p & sda_s;
	assign bus.idx = idx;
	assign bus.wr_data = sh;

	// Next phase; gate low drops any transfer at once
	always_comb begin
		next_st = st;
		next_bitc = bitc;
		next_sh = sh;
		next_idx = idx;
		next_rw = rw;
		next_aph = aph;
		next_ixp = ixp;
		next_oe = sda_oe;
		next_wr = 1'b0;
		if (!gate || stop) begin
			next_st = SER_IDLE;
			next_oe = 1'b0;
		end else if (start) begin
			next_st = SER_RX;
			next_bitc = 4'h0;
			next_aph = 1'b1;
			next_oe = 1'b0;
		end else begin
			case (st)
				SER_RX: begin
					if (rise) begin
						next_sh = {sh[6:0], sda_s};
						next_bitc = bitc + 4'h1;
					end else if (fall && bitc == 4'h8) begin
						next_st = SER_ACK;
						next_oe = 1'b1;
						if (aph) begin
							next_rw = sh[0];
							next_ixp = ~sh[0];
							if (sh[7:1] != `FMTC_DEV_ADDR) begin
								next_st = SER_IDLE;
								next_oe = 1'b0;
							end
						end else if (ixp) begin
							next_idx = sh[`FMTC_IDX_W-1:0];
						end else begin
							next_wr = 1'b1;
						end
					end
				end
				SER_ACK: begin
					if (fall) begin
						next_bitc = 4'h0;
						next_aph = 1'b0;
						next_ixp = aph & ~rw; // Index byte follows addr+W
						if (!aph && !ixp)
							next_idx = idx + 1'b1;
						if (rw) begin
							next_st = SER_TX;
							next_sh = bus.rd_data;
							next_oe = ~bus.rd_data[7];
						end else begin
							next_st = SER_RX;
							next_oe = 1'b0;
						end
					end
				end
				SER_TX: begin
					if (fall) begin
						next_bitc = bitc + 4'h1;
						next_sh = {sh[6:0], 1'b0};
						next_oe = ~sh[6];
						if (bitc == 4'h7) begin
							next_st = SER_RACK;
							next_oe = 1'b0;
							next_idx = idx + 1'b1;
						end
					end
				end
				SER_RACK: begin
					// Master nack ends the read; wait for stop
					if (rise && sda_s)
						next_st = SER_IDLE;
					else if (fall) begin
						next_st = SER_TX;
						next_bitc = 4'h0;
						next_sh = bus.rd_data;
						next_oe = ~bus.rd_data[7];
					end
				end
				default: begin
					next_st = SER_IDLE;
				end
			endcase
		end
	end

	// Slave state registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st <= SER_IDLE;
			bitc <= 4'h0;
			sh <= 8'h00;
			idx <= `FMTC_REG_STATUS;
			rw <= 1'b0;
			aph <= 1'b0;
			ixp <= 1'b0;
			sda_oe <= 1'b0;
			bus.wr_stb <= 1'b0;
			scl_p <= 1'b1;
			sda_p <= 1'b1;
		end else begin
			st <= next_st;
			bitc <= next_bitc;
			sh <= next_sh;
			idx <= next_idx;
			rw <= next_rw;
			aph <= next_aph;
			ixp <= next_ixp;
			sda_oe <= next_oe;
			bus.wr_stb <= next_wr;
			scl_p <= scl_s;
			sda_p <= sda_s;
		end
	end
endmodule : fmtc_i2c

/* fmtc_top.sv */
// FM tuning control: serial byte map, PLL retrigger and lock check,
// band/gain/AGC/reference selects and the free-running IF counter.
// Assumes the analog PLL, IF prescaler and search engine sit outside.
`timescale 1ns/1ps
`include "fmtc_defs.svh"

module fmtc_top
	import fmtc_pkg::*;
#(
	parameter int LOCK_MIN_US = `FMTC_T_LOCK_MIN_US,
	parameter int LOCK_MAX_US = `FMTC_T_LOCK_MAX_US,
	parameter int SHORT_US = `FMTC_T_SHORT_US,
	parameter int LONG_US = `FMTC_T_LONG_US,
	parameter logic [6:0] IF_WIN_LO = 7'h3C,
	parameter logic [6:0] IF_WIN_HI = 7'h44
)(
	input wire logic CLK, // 200 MHz system clock
	input wire logic RST_B, // Async reset, low
	input wire logic SERIAL_BUS_GATE, // Serial bus enable pin
	input wire logic SCL, // Serial clock pin
	input wire logic SDA_I, // Serial data pin level
	output logic SDA_O, // Serial data drive value
	output logic SDA_OE, // Serial data pull enable
	input wire logic XTAL_REF, // Crystal oscillator clock
	input wire logic EXTERNAL_REF_INPUT, // External reference clock
	input wire logic IF_IN, // Prescaled IF signal
	input wire logic PLL_LOCK_IN, // Raw PLL phase-lock level
	output logic REF_CLK_OUT, // Chosen 32.768 kHz reference
	output logic REF_SELECT_EXT, // External reference chosen
	output logic [13:0] PLL_DIVIDE, // Synthesizer divide word
	output logic PLL_RESTART, // One-cycle PLL retrigger
	output logic PLL_LOCK_FLAG, // Lock validated
	output logic SEARCH_RUN, // Autonomous search requested
	output logic SCAN_DIRECTION, // One is upward
	output logic BAND_SELECT, // One selects 76-90 MHz
	output logic LOCAL_GAIN_REDUCE, // LNA gain down 6 dB
	output logic RF_AGC_ENABLE, // Wideband AGC on
	output logic RDS_UPDATE, // One-cycle RDS update start
	output logic TUNE_BUSY, // Tuning cycle in progress
	output logic [6:0] IF_COUNT, // Latest IF count result
	output logic IF_FLAG // Count outside window
);
	localparam logic [21:0] LOCK_MIN_CYC = 22'(`FMTC_CYC_UP(LOCK_MIN_US));
	localparam logic [21:0] LOCK_MAX_CYC = 22'(`FMTC_CYC_DN(LOCK_MAX_US));
	localparam logic [21:0] SHORT_CYC = 22'(`FMTC_CYC_DN(SHORT_US));
	localparam logic [21:0] LONG_CYC = 22'(`FMTC_CYC_DN(LONG_US));

	fmtc_bus_if bus ();
	fmtc_tune_t st, next_st;
	logic [7:0] tune_word_high, tune_word_low, tuner_control_one;
	logic [7:0] tuner_control_two, test_bit_byte, test_select_byte;
	logic [7:0] next_high, next_low, next_one, next_two, next_tb, next_ts;
	logic [4:0] sy1, sy2; // First and second stages of the five pin synchronisers
	logic gate_s, scl_s, sda_s, xtal_s, ext_s;
	logic if_m, lock_m, if_s, if_p, lock_s;
	logic [21:0] tmr, next_tmr, per, next_per;
	logic [6:0] cnt, next_cnt, next_ifc;
	logic next_lock, next_flag, next_rds, next_restart, trig, short_sel;
	logic [13:0] next_div;

	// Byte index that restarts the PLL
	function automatic logic retrig(input logic [`FMTC_IDX_W-1:0] i);
		retrig = (i == `FMTC_REG_TUNE_HIGH) || (i == `FMTC_REG_TUNE_LOW) ||
			(i == `FMTC_REG_CTRL_ONE) || (i == `FMTC_REG_CTRL_TWO) ||
			(i == `FMTC_REG_TEST_BITS) || (i == `FMTC_REG_TEST_SEL);
	endfunction : retrig

	// ****************************************
	// Pin synchronisers
	// ****************************************
	// Two flops per pin; the second stage is read, and the IF pin also has a third flop, if_p, read for edges
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			sy1 <= 5'h1E;
			sy2 <= 5'h1E;
			{if_m, lock_m} <= 2'b00;
			{if_s, lock_s} <= 2'b00;
			if_p <= 1'b0;
		end else begin
			sy1 <= {SERIAL_BUS_GATE, SCL, SDA_I, XTAL_REF,
				EXTERNAL_REF_INPUT};
			sy2 <= sy1;
			{if_m, lock_m} <= {IF_IN, PLL_LOCK_IN};
			{if_s, lock_s} <= {if_m, lock_m};
			if_p <= if_s;
		end
	end
	assign {gate_s, scl_s, sda_s, xtal_s, ext_s} = sy2;

	// ****************************************
	// Serial slave
	// ****************************************
	fmtc_i2c u_ser (
		.clk(CLK),
		.rst_b(RST_B),
		.gate(gate_s),
		.scl_s(scl_s),
		.sda_s(sda_s),
		.sda_oe(SDA_OE),
		.bus(bus.slave)
	);
	assign SDA_O = 1'b0; // Open drain: only ever pulls low

	// Read-back of control bytes and own state
	always_comb begin
		bus.rd_data = `FMTC_BYTE_RESET;
		if (bus.idx == `FMTC_REG_STATUS)
			bus.rd_data = {PLL_LOCK_FLAG, IF_FLAG, TUNE_BUSY, 5'h00};
		else if (bus.idx == `FMTC_REG_IFCOUNT)
			bus.rd_data = {1'b0, IF_COUNT};
		else if (bus.idx == `FMTC_REG_TUNE_HIGH)
			bus.rd_data = tune_word_high;
		else if (bus.idx == `FMTC_REG_TUNE_LOW)
			bus.rd_data = tune_word_low;
		else if (bus.idx == `FMTC_REG_CTRL_ONE)
			bus.rd_data = tuner_control_one;
		else if (bus.idx == `FMTC_REG_CTRL_TWO)
			bus.rd_data = tuner_control_two;
		else if (bus.idx == `FMTC_REG_TEST_BITS)
			bus.rd_data = test_bit_byte;
		else if (bus.idx == `FMTC_REG_TEST_SEL)
			bus.rd_data = test_select_byte;
	end

	// ****************************************
	// Control bytes
	// ****************************************
	// Byte writes; status and count bytes are read only
	always_comb begin
		next_high = tune_word_high;
		next_low = tune_word_low;
		next_one = tuner_control_one;
		next_two = tuner_control_two;
		next_tb = test_bit_byte;
		next_ts = test_select_byte;
		if (bus.wr_stb) begin
			if (bus.idx == `FMTC_REG_TUNE_HIGH)
				next_high = bus.wr_data;
			else if (bus.idx == `FMTC_REG_TUNE_LOW)
				next_low = bus.wr_data;
			else if (bus.idx == `FMTC_REG_CTRL_ONE)
				next_one = bus.wr_data;
			else if (bus.idx == `FMTC_REG_CTRL_TWO)
				next_two = bus.wr_data;
			else if (bus.idx == `FMTC_REG_TEST_BITS)
				next_tb = bus.wr_data;
			else if (bus.idx == `FMTC_REG_TEST_SEL)
				next_ts = bus.wr_data;
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			tune_word_high <= `FMTC_BYTE_RESET;
			tune_word_low <= `FMTC_BYTE_RESET;
			tuner_control_one <= `FMTC_BYTE_RESET; // AGC-off bit clear
			tuner_control_two <= `FMTC_BYTE_RESET;
			test_bit_byte <= `FMTC_BYTE_RESET;
			test_select_byte <= `FMTC_BYTE_RESET;
		end else begin
			tune_word_high <= next_high;
			tune_word_low <= next_low;
			tuner_control_one <= next_one;
			tuner_control_two <= next_two;
			test_bit_byte <= next_tb;
			test_select_byte <= next_ts;
		end
	end

	// Selects taken straight from the control bytes; search run is also gated by busy
	assign BAND_SELECT = tuner_control_one[`FMTC_B_BAND];
	assign LOCAL_GAIN_REDUCE = tuner_control_one[`FMTC_B_LOCAL];
	assign RF_AGC_ENABLE = ~tuner_control_one[`FMTC_B_AGC_OFF];
	assign REF_SELECT_EXT = tuner_control_one[`FMTC_B_REF_EXT];
	assign REF_CLK_OUT = REF_SELECT_EXT ? ext_s : xtal_s;
	assign SEARCH_RUN = tune_word_high[`FMTC_B_SEARCH] & TUNE_BUSY;
	assign SCAN_DIRECTION = tune_word_high[`FMTC_B_SCAN_UP];
	assign short_sel = tuner_control_one[`FMTC_B_PERIOD];
	assign trig = bus.wr_stb & retrig(bus.idx);
	assign TUNE_BUSY = (st != TUNE_IDLE);

	// ****************************************
	// Tuning sequence
	// ****************************************
	// Retrigger, lock check, one count period, optional RDS update
	always_comb begin
		next_st = st;
		next_tmr = tmr + 22'h1;
		next_lock = PLL_LOCK_FLAG;
		next_rds = 1'b0;
		next_restart = 1'b0;
		next_div = PLL_DIVIDE;
		if (trig) begin
			// New tuning drops any old lock, even one just found
			next_st = TUNE_LOCK;
			next_tmr = 22'h0;
			next_lock = 1'b0;
			next_restart = 1'b1;
			next_div = {next_high[5:0], next_low};
		end else begin
			case (st)
				TUNE_LOCK: begin
					// Lock counts only after the shortest settle time
					if (tmr >= LOCK_MIN_CYC && lock_s) begin
						next_lock = 1'b1;
						next_st = TUNE_COUNT;
						next_tmr = 22'h0;
					end else if (tmr >= LOCK_MAX_CYC) begin
						next_st = TUNE_IDLE;
					end
				end
				TUNE_COUNT: begin
					// One full count period checks the new channel
					if (per == 22'h0 && tmr != 22'h0) begin
						if (short_sel && !tune_word_high[`FMTC_B_SEARCH]) begin
							next_st = TUNE_RDS;
							next_rds = 1'b1;
						end else begin
							next_st = TUNE_IDLE;
						end
					end
				end
				TUNE_RDS: begin
					// Update pulse stands here, so busy covers it
					next_st = TUNE_IDLE;
				end
				default: begin
					next_tmr = tmr;
				end
			endcase
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			st <= TUNE_IDLE;
			tmr <= 22'h0;
			PLL_LOCK_FLAG <= 1'b0;
			RDS_UPDATE <= 1'b0;
			PLL_RESTART <= 1'b0;
			PLL_DIVIDE <= 14'h0000;
		end else begin
			st <= next_st;
			tmr <= next_tmr;
			PLL_LOCK_FLAG <= next_lock;
			RDS_UPDATE <= next_rds;
			PLL_RESTART <= next_restart;
			PLL_DIVIDE <= next_div;
		end
	end

	// ****************************************
	// IF counter
	// ****************************************
	// Free-running gate; short period only inside a tuning cycle
	always_comb begin
		next_per = per - 22'h1;
		next_cnt = cnt;
		next_ifc = IF_COUNT;
		next_flag = IF_FLAG;
		if (if_s && !if_p)
			next_cnt = cnt + 7'h1; // Wraps: result is count mod 128
		if (trig) begin
			// Restart the gate so the first result is whole
			next_per = (short_sel ? SHORT_CYC : LONG_CYC) - 22'h1;
			next_cnt = 7'h00;
		end else if (per == 22'h0) begin
			next_ifc = next_cnt;
			next_flag = (next_cnt < IF_WIN_LO) || (next_cnt > IF_WIN_HI);
			next_cnt = 7'h00;
			if (st == TUNE_LOCK || st == TUNE_COUNT)
				next_per = (short_sel ? SHORT_CYC : LONG_CYC) - 22'h1;
			else
				next_per = LONG_CYC - 22'h1;
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			per <= 22'h0;
			cnt <= 7'h00;
			IF_COUNT <= 7'h00;
			IF_FLAG <= 1'b0;
		end else begin
			per <= next_per;
			cnt <= next_cnt;
			IF_COUNT <= next_ifc;
			IF_FLAG <= next_flag;
		end
	end
endmodule : fmtc_top

/* fmtc_top_properties.sv */
// Checker: retrigger, lock timing, RDS, IF window flag and bus gate.
// Assumes the 200 MHz CLK of fmtc_top; bound onto it at the foot.
`timescale 1ns/1ps
`include "fmtc_defs.svh"
// ****************************************
// Port checker
// ****************************************
module fmtc_chk #(
	parameter int LOCK_MIN_US = `FMTC_T_LOCK_MIN_US,
	parameter int LOCK_MAX_US = `FMTC_T_LOCK_MAX_US,
	parameter logic [6:0] IF_WIN_LO = 7'h3C,
	parameter logic [6:0] IF_WIN_HI = 7'h44
)(
	input wire logic CLK, // Clock
	input wire logic RST_B, // Reset, low
	input wire logic SERIAL_BUS_GATE, // Bus enable
	input wire logic SDA_OE, // Data pull
	input wire logic [13:0] PLL_DIVIDE, // Divide word
	input wire logic PLL_RESTART, // Retrigger
	input wire logic PLL_LOCK_FLAG, // Lock
	input wire logic SEARCH_RUN, // Search
	input wire logic RDS_UPDATE, // RDS pulse
	input wire logic TUNE_BUSY, // Busy
	input wire logic [6:0] IF_COUNT, // Count
	input wire logic IF_FLAG // Window flag
);
	localparam int LMIN = int'(`FMTC_CYC_DN(LOCK_MIN_US));
	localparam int LMAX = int'(`FMTC_CYC_UP(LOCK_MAX_US));
	logic [31:0] since;
	logic [31:0] next_since;
	// Cycles since retrigger; saturates so a long idle cannot wrap
	always_comb begin
		next_since = since;
		if (PLL_RESTART)
			next_since = 32'h0;
		else if (since != 32'hFFFFFFFF)
			next_since = since + 32'h1;
	end
	// Counter register
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B)
			since <= 32'h0;
		else
			since <= next_since;
	end
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_B);
	// Steps: the lock edge, and a gate held low long enough to sync
	sequence s_lock_rise;
		$rose(PLL_LOCK_FLAG);
	endsequence
	sequence s_gate_low;
		!SERIAL_BUS_GATE [*6];
	endsequence
	property p_lock_min; s_lock_rise |-> since >= LMIN - 3; endproperty
	a_lock_min: assert property (p_lock_min)
		else $error("Lock flag rose too early");
	property p_lock_max; s_lock_rise |-> since <= LMAX + 8; endproperty
	a_lock_max: assert property (p_lock_max)
		else $error("Lock flag rose too late");
	property p_restart; PLL_RESTART |-> TUNE_BUSY && !PLL_LOCK_FLAG; endproperty
	a_restart: assert property (p_restart)
		else $error("Retrigger without busy or with lock");
	property p_drop; $fell(PLL_LOCK_FLAG) |-> PLL_RESTART; endproperty
	a_drop: assert property (p_drop)
		else $error("Lock flag dropped without retrigger");
	property p_pulse; PLL_RESTART |=> !PLL_RESTART; endproperty
	a_pulse: assert property (p_pulse)
		else $error("Retrigger longer than one cycle");
	property p_busy; $rose(TUNE_BUSY) |-> PLL_RESTART; endproperty
	a_busy: assert property (p_busy)
		else $error("Tuning began without retrigger");
	property p_divide; $changed(PLL_DIVIDE) |-> PLL_RESTART; endproperty
	a_divide: assert property (p_divide)
		else $error("Divide word moved without retrigger");
	property p_rds;
		RDS_UPDATE |-> (TUNE_BUSY && !SEARCH_RUN) ##1 !RDS_UPDATE;
	endproperty
	a_rds: assert property (p_rds)
		else $error("RDS update out of a preset tuning");
	property p_if_flag;
		$changed(IF_COUNT) |=> IF_FLAG ==
			(IF_COUNT < IF_WIN_LO || IF_COUNT > IF_WIN_HI);
	endproperty
	a_if_flag: assert property (p_if_flag)
		else $error("IF flag disagrees with the window");
	property p_gate; s_gate_low |-> !SDA_OE; endproperty
	a_gate: assert property (p_gate)
		else $error("Data line pulled while bus gated off");
endmodule : fmtc_chk

bind fmtc_top fmtc_chk #(.LOCK_MIN_US(LOCK_MIN_US),
	.LOCK_MAX_US(LOCK_MAX_US), .IF_WIN_LO(IF_WIN_LO),
	.IF_WIN_HI(IF_WIN_HI)) fmtc_chk_inst (.CLK, .RST_B,
	.SERIAL_BUS_GATE, .SDA_OE, .PLL_DIVIDE, .PLL_RESTART, .PLL_LOCK_FLAG,
	.SEARCH_RUN, .RDS_UPDATE, .TUNE_BUSY, .IF_COUNT, .IF_FLAG);

/* fmtc_host.sv */
// Host model: serial master writing and reading the tuning bytes.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/1ps
`include "fmtc_defs.svh"
// ****************************************
// Serial host
// ****************************************
module fmtc_host (
	input wire logic clk, // System clock
	input wire logic sda, // Resolved data wire
	output logic scl, // Clock line, still high between frames
	output logic sda_low // Pull data line low
);
	// Idle bus: both lines released
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// Tuning word from kHz; integer divide truncates, never rounds up
	function automatic logic [13:0] tune_word(input int f_khz, input bit hi);
		longint n;
		n = hi ? f_khz + 225 : f_khz - 225;
		return 14'((n * 4000) / 32768);
	endfunction : tune_word
	// Quarter bit is 8 cycles, so the clock line runs at 160 ns
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask : tick
	task automatic start();
		sda_low = 1'b0;
		tick(8);
		sda_low = 1'b1;
		tick(8);
		scl = 1'b0;
		tick(8);
	endtask : start
	task automatic stop();
		sda_low = 1'b1;
		tick(8);
		scl = 1'b1;
		tick(8);
		sda_low = 1'b0;
		tick(8);
	endtask : stop
	// Data changes only while the clock line is low
	task automatic put_bit(input logic b);
		sda_low = ~b;
		tick(8);
		scl = 1'b1;
		tick(16);
		scl = 1'b0;
		tick(8);
	endtask : put_bit
	task automatic get_bit(output logic b);
		sda_low = 1'b0;
		tick(8);
		scl = 1'b1;
		tick(8);
		b = sda;
		tick(8);
		scl = 1'b0;
		tick(8);
	endtask : get_bit
	task automatic send_byte(input logic [7:0] d, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--)
			put_bit(d[i]);
		get_bit(b);
		ack = ~b;
	endtask : send_byte
	// Up to two data bytes from idx; the slave auto-increments
	task automatic write_regs(input logic [7:0] idx, input logic [15:0] d,
		input int n, output logic ok);
		logic a;
		start();
		send_byte({`FMTC_DEV_ADDR, 1'b0}, ok);
		send_byte(idx, a);
		ok = ok & a;
		for (int k = n - 1; k >= 0; k--) begin
			send_byte(d[8*k +: 8], a);
			ok = ok & a;
		end
		stop();
	endtask : write_regs
	// Index write and stop, new start, one byte read, then NACK
	task automatic read_reg(input logic [7:0] idx, output logic [7:0] d,
		output logic ok);
		logic a;
		write_regs(idx, 16'h0000, 0, ok);
		start();
		send_byte({`FMTC_DEV_ADDR, 1'b1}, a);
		ok = ok & a;
		for (int i = 7; i >= 0; i--)
			get_bit(d[i]);
		put_bit(1'b1);
		stop();
	endtask : read_reg
endmodule : fmtc_host

/* tb.sv */
// Bench for the FM tuning control top: tuning, IF count, bus gate.
// Assumes design, checker and host model are compiled before it.
`timescale 1ns/1ps
// ****************************************
// Bench top
// ****************************************
module tb;
	logic CLK = 1'b0;
	logic RST_B = 1'b0;
	logic SERIAL_BUS_GATE = 1'b1;
	logic PLL_LOCK_IN = 1'b1;
	logic IF_IN = 1'b0, XTAL_REF = 1'b0, EXTERNAL_REF_INPUT = 1'b0;
	wire SCL, SDA_I, host_low;
	logic SDA_OE, REF_CLK_OUT, REF_SELECT_EXT, PLL_RESTART, PLL_LOCK_FLAG;
	logic SEARCH_RUN, SCAN_DIRECTION, BAND_SELECT, LOCAL_GAIN_REDUCE;
	logic RF_AGC_ENABLE, RDS_UPDATE, TUNE_BUSY, IF_FLAG;
	logic [13:0] PLL_DIVIDE;
	logic [6:0] IF_COUNT;
	int num_errors = 0;
	int n_tests = 0;
	int t = 0;
	int if_half = 25;
	// Open-drain wire with pull-up
	assign SDA_I = (host_low | SDA_OE) ? 1'b0 : 1'b1;
	// Short lock and count times keep the run brief
	fmtc_top #(.LOCK_MIN_US(2), .LOCK_MAX_US(10), .SHORT_US(2),
		.LONG_US(16)) fmtc_top_inst (.CLK, .RST_B, .SERIAL_BUS_GATE, .SCL,
		.SDA_I, .SDA_O(), .SDA_OE, .XTAL_REF, .EXTERNAL_REF_INPUT, .IF_IN,
		.PLL_LOCK_IN, .REF_CLK_OUT, .REF_SELECT_EXT, .PLL_DIVIDE,
		.PLL_RESTART, .PLL_LOCK_FLAG, .SEARCH_RUN, .SCAN_DIRECTION,
		.BAND_SELECT, .LOCAL_GAIN_REDUCE, .RF_AGC_ENABLE, .RDS_UPDATE,
		.TUNE_BUSY, .IF_COUNT, .IF_FLAG);
	fmtc_host fmtc_host_inst (.clk(CLK), .sda(SDA_I), .scl(SCL),
		.sda_low(host_low));
	// 200 MHz clock
	always #2.5 CLK = ~CLK;
	// IF and reference sources, stepped on the falling edge
	always @(negedge CLK) begin
		t <= t + 1;
		IF_IN <= 1'((t / if_half) % 2);
		XTAL_REF <= 1'((t / 40) % 2);
		EXTERNAL_REF_INPUT <= 1'((t / 25) % 2);
	end
	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : final_report
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk
	// Bounded waits; a spent bound ends the run as a failure
	task automatic wait_lock();
		int i;
		for (i = 0; i < 2400 && PLL_LOCK_FLAG !== 1'b1; i++)
			@(negedge CLK);
		chk(16'(PLL_LOCK_FLAG), 16'h1);
		if (i == 2400)
			final_report();
	endtask : wait_lock
	task automatic wait_idle(output int rds);
		int i;
		rds = 0;
		for (i = 0; i < 4000 && TUNE_BUSY !== 1'b0; i++) begin
			@(negedge CLK);
			if (RDS_UPDATE === 1'b1)
				rds++;
		end
		chk(16'(TUNE_BUSY), 16'h0);
		if (i == 4000)
			final_report();
	endtask : wait_idle
	// Short period, preset tune to 100.1 MHz, high-side
	task automatic t_preset();
		logic ok;
		logic [13:0] w;
		int rds;
		chk(16'({RF_AGC_ENABLE, TUNE_BUSY, BAND_SELECT}), 16'h4);
		fmtc_host_inst.write_regs(8'h04, 16'h001F, 1, ok);
		chk(16'(ok), 16'h1);
		chk(16'({BAND_SELECT, LOCAL_GAIN_REDUCE, RF_AGC_ENABLE,
			REF_SELECT_EXT}), 16'hD);
		w = fmtc_host_inst.tune_word(100100, 1'b1);
		fmtc_host_inst.write_regs(8'h02, {2'b00, w}, 2, ok);
		chk(16'(PLL_DIVIDE), 16'h2FD6);
		chk(16'({SEARCH_RUN, SCAN_DIRECTION}), 16'h0);
		wait_lock();
		wait_idle(rds);
		chk(16'(rds), 16'h1);
		chk(16'({IF_FLAG, IF_COUNT}), 16'h88);
	endtask : t_preset
	// Counts after tuning use the long period; then leave the window
	task automatic t_ifcount();
		logic ok;
		logic [7:0] b;
		logic prev;
		int c;
		repeat (7000) @(negedge CLK);
		chk(16'(IF_COUNT inside {[7'h3F:7'h41]}), 16'h1);
		chk(16'(IF_FLAG), 16'h0);
		fmtc_host_inst.read_reg(8'h01, b, ok);
		chk(16'(ok && b inside {[8'h3F:8'h41]}), 16'h1);
		fmtc_host_inst.read_reg(8'h00, b, ok);
		chk(16'(b), 16'h0080);
		c = 0;
		prev = REF_CLK_OUT;
		repeat (500) begin
			@(negedge CLK);
			if (REF_CLK_OUT === 1'b1 && prev === 1'b0)
				c++;
			prev = REF_CLK_OUT;
		end
		chk(16'(c >= 9 && c <= 11), 16'h1);
		if_half = 20;
		repeat (7000) @(negedge CLK);
		chk(16'(IF_FLAG), 16'h1);
	endtask : t_ifcount
	// Long period, upward search from 90 MHz, low-side word
	task automatic t_search();
		logic ok;
		logic [13:0] w;
		int rds;
		fmtc_host_inst.write_regs(8'h04, 16'h0000, 1, ok);
		chk(16'(PLL_LOCK_FLAG), 16'h0);
		chk(16'({BAND_SELECT, RF_AGC_ENABLE, REF_SELECT_EXT}), 16'h2);
		w = fmtc_host_inst.tune_word(90000, 1'b0);
		fmtc_host_inst.write_regs(8'h02, {2'b11, w}, 2, ok);
		chk(16'(PLL_DIVIDE), 16'h2ACE);
		chk(16'({SEARCH_RUN, SCAN_DIRECTION}), 16'h3);
		wait_lock();
		wait_idle(rds);
		chk(16'(rds), 16'h0);
		fmtc_host_inst.write_regs(8'h01, 16'h00FF, 1, ok);
		chk(16'({ok, TUNE_BUSY}), 16'h2);
	endtask : t_search
	// Gate low refuses the whole transfer; then a lock that never comes
	task automatic t_gate();
		logic ok;
		SERIAL_BUS_GATE = 1'b0;
		fmtc_host_inst.write_regs(8'h04, 16'h0001, 1, ok);
		chk(16'({ok, BAND_SELECT, TUNE_BUSY}), 16'h0);
		SERIAL_BUS_GATE = 1'b1;
		PLL_LOCK_IN = 1'b0;
		repeat (4) @(negedge CLK);
		fmtc_host_inst.write_regs(8'h04, 16'h0001, 1, ok);
		chk(16'({ok, BAND_SELECT}), 16'h3);
		repeat (2100) @(negedge CLK);
		chk(16'({PLL_LOCK_FLAG, TUNE_BUSY}), 16'h0);
		PLL_LOCK_IN = 1'b1;
	endtask : t_gate
	// Reset, then the scenarios in order
	initial begin
		repeat (3) @(negedge CLK);
		RST_B = 1'b1;
		repeat (3) @(negedge CLK);
		t_preset();
		t_ifcount();
		t_search();
		t_gate();
		final_report();
	end
endmodule : tb
